// ---- rtl/osdrc_pkg.sv ----
package osdrc_pkg;
	// ==========================================
	// Timing
	localparam int CLK_KHZ        = 40000;
	localparam int FLASH_TICK_MS  = 250;
	localparam int FLASH_TICK_CYC = FLASH_TICK_MS * CLK_KHZ;
	// ==========================================
	// Screen geometry
	localparam logic [3:0] ROWS      = 4'hC;
	localparam logic [4:0] COLS      = 5'h18;
	localparam logic [4:0] HALF_COLS = 5'h0C;
	localparam logic [8:0] LAST_CELL = 9'h11F;
	localparam logic [7:0] GLYPH_BLANK = 8'hFE;
	// ==========================================
	// Factory options and background modes
	localparam logic [1:0] OPT_A  = 2'h0;
	localparam logic [1:0] OPT_B  = 2'h1;
	localparam logic [1:0] OPT_C  = 2'h2;
	localparam logic [1:0] BG_NONE = 2'h0;
	localparam logic [1:0] BG_MIN  = 2'h1;
	// ==========================================
	// Opcodes
	localparam logic [3:0] OP1_CLEAR = 4'h0;
	localparam logic [3:0] OP1_DISP  = 4'h1;
	localparam logic [3:0] OP1_COLOR = 4'h2;
	localparam logic [3:0] OP1_INV   = 4'h3;
	localparam logic [3:0] OP1_CHAN  = 4'h7;
	localparam logic [2:0] INV_SUB   = 3'h4;
	localparam logic [4:0] OP2_POS   = 5'h10;
	localparam logic [4:0] OP2_ADDR  = 5'h11;
	localparam logic [7:0] OP2_PIN   = 8'h9C;
	localparam logic [7:0] OP2_SIZE  = 8'h98;
	localparam logic [6:0] OP2_BG    = 7'h59;
	localparam logic [1:0] OP2_CHAR  = 2'h3;
	// ==========================================
	// Field positions
	localparam int DISP_TEXT = 3;
	localparam int DISP_OSC  = 2;
	localparam int PIN_M2    = 7;
	localparam int PIN_M1    = 6;
	localparam int SIZE_BIT  = 6;
	localparam int ATTR_MARK = 8;
	localparam int ATTR_FLSH = 9;
	localparam int ATTR_INV  = 13;
	// ==========================================
	// Register map and reset values
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_ROUTE1 = 3'h2;
	localparam logic [2:0] REG_ROUTE2 = 3'h3;
	localparam logic [2:0] REG_SIZE   = 3'h4;
	localparam logic [15:0] CTRL_RST  = 16'h0001;
	localparam logic [2:0] CHAN_ON_RST = 3'h7;

	typedef enum logic [3:0] {
		ST_FIRST  = 4'h1,
		ST_SECOND = 4'h2,
		ST_CONT   = 4'h4,
		ST_CLEAR  = 4'h8
	} osdrc_state_t;
endpackage

// ---- rtl/osdrc_top.sv ----
`timescale 1ns/1ps
// What this block does
// - Colour channel never shows characters marked for the second mono output.
// - Option A: first mono shows unmarked characters in rows with mono_out_one 0.
// - Option A: first mono stays low in rows with mono_out_one 1.
// - Option A: second mono low when mono_out_one 0, else marked characters only.
// - Option B: first mono shows all rows, minus marked characters.
// - Option B: second mono shows marked characters only where mono_out_one is 1.
// - Option C, mono_out_two 0: first mono columns 0-23 or 0-11.
// - Option C, mono_out_two 1: first mono columns 12-23, or low.
// - Option C, mono_out_one 0: second mono columns 0-11, or low.
// - Option C, mono_out_one 1: second mono columns 12-23 or 0-23.
// - Marked characters get no background on colour or first mono.
// - Neighbour rim or background spills one dot into blank cells.
// - Into marked cells, colour and first mono take neighbour rim, not background.
// - Second mono: rim spills into blank cells and between marked cells; background into blank cells only.
// - Background mode and rim are held separately for each channel.
// - Serial commands come in bytes: one-byte, two-byte, continuous two-byte.
// - Bit order is fixed by a factory option; host must match.
// - One-byte opcodes: clear, display control, colours, inverse, channel on/off.
// - Two-byte opcodes: display position and write address.
// - Output pin control and row size control, per row.
// - Per-channel background control; test mode word is ignored.
// - While osc_run_q is 1, top bits 11 write a displayed character with attributes and glyph.
// - Power-on and clear-all zero both mono routing bit sets.
// - Flash rate 00 off, 01 2 Hz, 10 1 Hz, 11 0.5 Hz, 1:1 duty.
module osdrc_top
	import osdrc_pkg::*;
#(
	parameter logic [1:0] OPTION    = OPT_B,
	parameter bit         MSB_FIRST = 1'b1,
	parameter int         FLASH_CYC = FLASH_TICK_CYC
)(
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_SCK,
	input  wire logic        I_SDA,
	input  wire logic        I_CS_N,
	input  wire logic [2:0]  I_ADDR,
	input  wire logic [15:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [15:0] O_RDATA,
	input  wire logic [3:0]  I_ROW,
	input  wire logic [4:0]  I_COL,
	input  wire logic        I_PIX,
	input  wire logic        I_RIM,
	input  wire logic        I_MINBG,
	input  wire logic        I_NB_RIM,
	input  wire logic        I_NB_BG,
	input  wire logic        I_NB_MARK,
	output logic      [7:0]  O_GLYPH,
	output logic             O_VR,
	output logic             O_VG,
	output logic             O_VB,
	output logic             O_VBLK,
	output logic             O_MONO1,
	output logic             O_MONO1_BLK,
	output logic             O_MONO2,
	output logic             O_MONO2_BLK,
	output logic             O_OSC_RUN,
	output logic             O_ROW_DBL,
	output logic      [4:0]  O_VPOS,
	output logic      [4:0]  O_HPOS
);
	// ==========================================
	// Helpers
	function automatic logic [8:0] cell_idx(input logic [3:0] r, input logic [4:0] c);
		cell_idx = {5'h00, r} * 9'h018 + {4'h0, c};
	endfunction

	// Returns {char, rim, background} for one channel
	function automatic logic [2:0] chan_dot(input logic [1:0] mode, input logic rimf,
		input logic own, input logic chr, input logic nbr_ok, input logic nbb_ok,
		input logic rim, input logic minbg, input logic nbr, input logic nbb);
		logic bg_on;
		bg_on = (mode == BG_MIN) ? minbg : (mode != BG_NONE);
		chan_dot[2] = chr;
		chan_dot[1] = rimf & ((own & rim) | (nbr_ok & nbr));
		chan_dot[0] = (own & bg_on) | (nbb_ok & (mode != BG_NONE) & nbb);
	endfunction

	// ==========================================
	// Serial input synchronisers
	logic [2:0] sck_q;
	logic [1:0] sda_q;
	logic [1:0] cs_q;
	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
		begin
			sck_q <= 3'h0;
			sda_q <= 2'h0;
			cs_q  <= 2'h3;
		end
		else
		begin
			sck_q <= {sck_q[1:0], I_SCK};
			sda_q <= {sda_q[0], I_SDA};
			cs_q  <= {cs_q[0], I_CS_N};
		end

	logic sck_rise;
	logic frame_on;
	assign sck_rise = sck_q[1] & ~sck_q[2];
	assign frame_on = ~cs_q[1];

	// ==========================================
	// Byte assembly
	logic [6:0] shift_q;
	logic [2:0] bitcnt_q;
	logic       byte_done;
	logic [7:0] byte_val;
	assign byte_val  = MSB_FIRST ? {shift_q, sda_q[1]} : {sda_q[1], shift_q};
	assign byte_done = sck_rise & frame_on & (bitcnt_q == 3'h7);

	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
		begin
			shift_q  <= 7'h00;
			bitcnt_q <= 3'h0;
		end
		else if (!frame_on)
			bitcnt_q <= 3'h0;
		else if (sck_rise)
		begin
			shift_q  <= MSB_FIRST ? byte_val[6:0] : byte_val[7:1];
			bitcnt_q <= bitcnt_q + 3'h1;
		end

	// ==========================================
	// Command state and configuration
	osdrc_state_t st_q;
	logic [15:0] ctrl_q;
	logic [7:0]  hi_q;
	logic [5:0]  attr_q;
	logic [8:0]  clr_q;
	logic [3:0]  wr_row_q;
	logic [4:0]  wr_col_q;
	logic [11:0] route1_q;
	logic [11:0] route2_q;
	logic [11:0] size_q;
	logic        text_on_q;
	logic        osc_run_q;
	logic [1:0]  flash_rate_q;
	logic        rim_tone_q;
	logic [2:0]  bg_rgb_q;
	logic        inv_en_q;
	logic [2:0]  chan_on_q;
	logic [8:0]  bgctl_q;
	logic [4:0]  vpos_q;
	logic [4:0]  hpos_q;

	logic        accept;
	logic        char_we;
	logic [13:0] char_word;
	logic [15:0] w;
	assign accept = byte_done & ctrl_q[0] & (st_q != ST_CLEAR);
	assign w      = {hi_q, byte_val};
	assign char_we = accept & osc_run_q
		& ((st_q == ST_SECOND && hi_q[7:6] == OP2_CHAR) || st_q == ST_CONT);
	assign char_word = (st_q == ST_CONT) ? {attr_q, byte_val} : {hi_q[5:0], byte_val};

	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
		begin
			st_q         <= ST_CLEAR;
			hi_q         <= 8'h00;
			attr_q       <= 6'h00;
			clr_q        <= 9'h000;
			wr_row_q     <= 4'h0;
			wr_col_q     <= 5'h00;
			route1_q     <= 12'h000;
			route2_q     <= 12'h000;
			size_q       <= 12'h000;
			text_on_q    <= 1'b0;
			osc_run_q    <= 1'b1;
			flash_rate_q <= 2'h0;
			rim_tone_q   <= 1'b0;
			bg_rgb_q     <= 3'h0;
			inv_en_q     <= 1'b0;
			chan_on_q    <= CHAN_ON_RST;
			bgctl_q      <= 9'h000;
			vpos_q       <= 5'h00;
			hpos_q       <= 5'h00;
		end
		else
		begin
			if (char_we)
			begin
				// Write address advances along the row, then wraps to the next row
				if (wr_col_q == COLS - 5'h01)
				begin
					wr_col_q <= 5'h00;
					wr_row_q <= (wr_row_q == ROWS - 4'h1) ? 4'h0 : wr_row_q + 4'h1;
				end
				else
					wr_col_q <= wr_col_q + 5'h01;
			end
			case (st_q)
				ST_CLEAR:
				begin
					clr_q <= clr_q + 9'h001;
					if (clr_q == LAST_CELL)
						st_q <= ST_FIRST;
				end
				ST_FIRST:
				begin
					if (accept && byte_val[7])
					begin
						hi_q <= byte_val;
						st_q <= ST_SECOND;
					end
					else if (accept)
					begin
						case (byte_val[7:4])
							OP1_CLEAR:
							begin
								st_q         <= ST_CLEAR;
								clr_q        <= 9'h000;
								wr_row_q     <= 4'h0;
								wr_col_q     <= 5'h00;
								route1_q     <= 12'h000;
								route2_q     <= 12'h000;
								size_q       <= 12'h000;
								text_on_q    <= 1'b0;
								osc_run_q    <= 1'b1;
								flash_rate_q <= 2'h0;
							end
							OP1_DISP:
							begin
								text_on_q    <= byte_val[DISP_TEXT];
								osc_run_q    <= byte_val[DISP_OSC];
								flash_rate_q <= byte_val[1:0];
							end
							OP1_COLOR:
							begin
								bg_rgb_q   <= byte_val[3:1];
								rim_tone_q <= byte_val[0];
							end
							OP1_INV:
								if (byte_val[3:1] == INV_SUB)
									inv_en_q <= byte_val[0];
							OP1_CHAN:
								if (!byte_val[3])
									chan_on_q <= byte_val[2:0];
							default:
								chan_on_q <= chan_on_q;
						endcase
					end
				end
				ST_SECOND:
				begin
					if (!frame_on)
						st_q <= ST_FIRST;
					else if (accept)
					begin
						st_q <= ST_FIRST;
						if (w[15:14] == OP2_CHAR)
						begin
							attr_q <= hi_q[5:0];
							st_q   <= ST_CONT;
						end
						else if (w[15:11] == OP2_POS)
						begin
							vpos_q <= w[9:5];
							hpos_q <= w[4:0];
						end
						else if (w[15:11] == OP2_ADDR && w[10:9] == 2'h0)
						begin
							if (w[8:5] < ROWS && w[4:0] < COLS)
							begin
								wr_row_q <= w[8:5];
								wr_col_q <= w[4:0];
							end
						end
						else if (w[15:8] == OP2_PIN && w[3:0] < ROWS)
						begin
							route2_q[w[3:0]] <= w[PIN_M2];
							route1_q[w[3:0]] <= w[PIN_M1];
						end
						else if (w[15:8] == OP2_SIZE && w[3:0] < ROWS)
							size_q[w[3:0]] <= w[SIZE_BIT];
						else if (w[15:9] == OP2_BG)
							bgctl_q <= w[8:0];
						// Test mode words fall through and are dropped
					end
				end
				ST_CONT:
					if (!frame_on)
						st_q <= ST_FIRST;
				default:
					st_q <= ST_FIRST;
			endcase
		end

	// ==========================================
	// Character memory; not reset, the clear sweep fills it
	logic [13:0] vram_q [0:287];
	always_ff @(posedge I_CLK)
		if (st_q == ST_CLEAR)
			vram_q[clr_q] <= {6'h00, GLYPH_BLANK};
		else if (char_we)
			vram_q[cell_idx(wr_row_q, wr_col_q)] <= char_word;

	// ==========================================
	// Flash timebase
	logic [23:0] fcnt_q;
	logic [2:0]  fph_q;
	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
		begin
			fcnt_q <= 24'h000000;
			fph_q  <= 3'h0;
		end
		else if (fcnt_q == 24'(FLASH_CYC - 1))
		begin
			fcnt_q <= 24'h000000;
			fph_q  <= fph_q + 3'h1;
		end
		else
			fcnt_q <= fcnt_q + 24'h000001;

	logic flash_vis;
	always_comb
		case (flash_rate_q)
			2'h1:    flash_vis = ~fph_q[0];
			2'h2:    flash_vis = ~fph_q[1];
			2'h3:    flash_vis = ~fph_q[2];
			default: flash_vis = 1'b1;
		endcase

	// ==========================================
	// Display stage 1: cell fetch
	logic [13:0] cell_q;
	logic [3:0]  row_q;
	logic [4:0]  col_q;
	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
		begin
			cell_q <= {6'h00, GLYPH_BLANK};
			row_q  <= 4'h0;
			col_q  <= 5'h00;
		end
		else
		begin
			// Blank while sweeping so the unwritten memory never reaches the pins
			cell_q <= (st_q != ST_CLEAR && I_ROW < ROWS && I_COL < COLS) ? vram_q[cell_idx(I_ROW, I_COL)]
				: {6'h00, GLYPH_BLANK};
			row_q  <= I_ROW;
			col_q  <= I_COL;
		end

	// ==========================================
	// Display stage 2: routing
	logic marked;
	logic blank;
	logic row_ok;
	logic m1r;
	logic m2r;
	logic left;
	logic en1;
	logic en2;
	logic px;
	assign marked = cell_q[ATTR_MARK];
	assign blank  = cell_q[7:0] == GLYPH_BLANK;
	assign row_ok = row_q < ROWS;
	assign m1r    = row_ok & route1_q[row_q];
	assign m2r    = row_ok & route2_q[row_q];
	assign left   = col_q < HALF_COLS;
	assign px     = text_on_q & ~blank & (flash_vis | ~cell_q[ATTR_FLSH])
		& (I_PIX ^ (inv_en_q & cell_q[ATTR_INV]));

	always_comb
		case (OPTION)
			OPT_A:
			begin
				en1 = ~m1r;
				en2 = m1r;
			end
			OPT_C:
			begin
				en1 = m2r ? (~m1r & ~left) : (~m1r | left);
				en2 = m1r ? (m2r | ~left) : (m2r & left);
			end
			default:
			begin
				en1 = 1'b1;
				en2 = m1r;
			end
		endcase

	logic [2:0] a_dot;
	logic [2:0] b_dot;
	logic [2:0] c_dot;
	// Each channel has its own background mode and rim flag
	assign a_dot = chan_dot(bgctl_q[8:7], bgctl_q[6], ~marked, px & chan_on_q[2] & ~marked,
		blank | marked, blank & ~marked, I_RIM, I_MINBG, I_NB_RIM, I_NB_BG);
	assign b_dot = chan_dot(bgctl_q[5:4], bgctl_q[3], ~marked, px & chan_on_q[1] & ~marked & en1,
		blank | marked, blank & ~marked, I_RIM, I_MINBG, I_NB_RIM, I_NB_BG);
	assign c_dot = chan_dot(bgctl_q[2:1], bgctl_q[0], marked, px & chan_on_q[0] & marked & en2,
		blank | (marked & I_NB_MARK), blank, I_RIM, I_MINBG, I_NB_RIM, I_NB_BG);

	// ==========================================
	// Output registers; mono rim and background are black, so only blanking shows them
	logic [7:0] out_q;
	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
			out_q <= 8'h00;
		else
		begin
			out_q[7] <= a_dot[2] ? cell_q[12] : a_dot[1] ? rim_tone_q : a_dot[0] & bg_rgb_q[2];
			out_q[6] <= a_dot[2] ? cell_q[11] : a_dot[1] ? rim_tone_q : a_dot[0] & bg_rgb_q[1];
			out_q[5] <= a_dot[2] ? cell_q[10] : a_dot[1] ? rim_tone_q : a_dot[0] & bg_rgb_q[0];
			out_q[4] <= |a_dot;
			out_q[3] <= b_dot[2];
			out_q[2] <= |b_dot;
			out_q[1] <= c_dot[2];
			out_q[0] <= |c_dot;
		end

	logic dbl_q;
	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
			dbl_q <= 1'b0;
		else
			dbl_q <= row_ok & size_q[row_q];

	assign {O_VR, O_VG, O_VB, O_VBLK} = out_q[7:4];
	assign {O_MONO1, O_MONO1_BLK, O_MONO2, O_MONO2_BLK} = out_q[3:0];
	assign O_GLYPH   = cell_q[7:0];
	assign O_OSC_RUN = osc_run_q;
	assign O_ROW_DBL = dbl_q;
	assign O_VPOS    = vpos_q;
	assign O_HPOS    = hpos_q;

	// ==========================================
	// Register port
	logic [15:0] rdata_q;
	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
			ctrl_q <= CTRL_RST;
		else if (I_WR && I_ADDR == REG_CTRL)
			ctrl_q <= {15'h0000, I_WDATA[0]};

	always_ff @(posedge I_CLK or posedge I_RST)
		if (I_RST)
			rdata_q <= 16'h0000;
		else if (!I_RD)
			rdata_q <= 16'h0000;
		else
			case (I_ADDR)
				REG_CTRL:   rdata_q <= ctrl_q;
				REG_STATUS: rdata_q <= {6'h00, st_q, text_on_q, osc_run_q, flash_rate_q, inv_en_q, rim_tone_q};
				REG_ROUTE1: rdata_q <= {4'h0, route1_q};
				REG_ROUTE2: rdata_q <= {4'h0, route2_q};
				REG_SIZE:   rdata_q <= {4'h0, size_q};
				default:    rdata_q <= 16'h0000;
			endcase
	assign O_RDATA = rdata_q;

	// ==========================================
	// Checks
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	rgb_mark_a: assert property (marked |-> !a_dot[2] && !a_dot[0])
		else $error("colour shows a marked cell");
	bg_mark_a: assert property (marked |=> !O_MONO1 && !(out_q[4] && !$past(I_RIM || I_NB_RIM)))
		else $error("background on a marked cell");
	opta_mono1_a: assert property (OPTION == OPT_A && m1r |=> !O_MONO1)
		else $error("first mono not low");
	opta_mono2_a: assert property (OPTION == OPT_A && !m1r |=> !O_MONO2)
		else $error("second mono not low");
	optb_mono2_a: assert property (OPTION == OPT_B && !m1r |=> !O_MONO2)
		else $error("second mono shows a row it should not");
	optc_mono1_a: assert property (OPTION == OPT_C && m1r && m2r |=> !O_MONO1)
		else $error("first mono not low in option C");
	optc_mono2_a: assert property (OPTION == OPT_C && !m1r && (!m2r || !left) |=> !O_MONO2)
		else $error("second mono wrong half");
	clear_route_a: assert property (accept && st_q == ST_FIRST && byte_val == 8'h00
		|=> route1_q == 12'h000 && route2_q == 12'h000 && st_q == ST_CLEAR)
		else $error("clear left routing bits");
	byte_count_a: assert property (!frame_on |=> bitcnt_q == 3'h0)
		else $error("partial byte kept across frames");
	char_adv_a: assert property (char_we && wr_col_q < COLS - 5'h01 |=> wr_col_q == $past(wr_col_q) + 5'h01)
		else $error("write address did not advance");
endmodule

// ---- testbench/osdrc_host_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Host end of the serial command link
module osdrc_host_model #(
	parameter bit MSB_FIRST = 1'b1,
	parameter int HALF_CYC  = 4
)(
	input  wire logic i_clk,
	output logic      o_sck,
	output logic      o_sda,
	output logic      o_cs_n
);
	initial
	begin
		o_sck  = 1'b0;
		o_sda  = 1'b0;
		o_cs_n = 1'b1;
	end
	task automatic wait_half();
		repeat (HALF_CYC) @(posedge i_clk);
	endtask
	task automatic frame_open();
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		wait_half();
	endtask
	// Data is inverted at frame end so a stale level never passes for a held bit
	task automatic frame_close();
		wait_half();
		o_cs_n <= 1'b1;
		o_sck  <= 1'b0;
		o_sda  <= ~o_sda;
		wait_half();
	endtask
	task automatic put_byte(input logic [7:0] b);
		for (int k = 0; k < 8; k++)
		begin
			o_sck <= 1'b0;
			o_sda <= MSB_FIRST ? b[7 - k] : b[k];
			wait_half();
			o_sck <= 1'b1;
			wait_half();
		end
	endtask
	// High byte goes first
	task automatic put_word(input logic [15:0] w);
		put_byte(w[15:8]);
		put_byte(w[7:0]);
	endtask
	task automatic send1(input logic [7:0] b);
		frame_open();
		put_byte(b);
		frame_close();
	endtask
	task automatic send2(input logic [15:0] w);
		frame_open();
		put_word(w);
		frame_close();
	endtask
endmodule

// ---- testbench/osd_channel_routing_cmd_tb_top.sv ----
`timescale 1ns/1ps
module osd_channel_routing_cmd_tb_top import osdrc_pkg::*;;
	logic        clk;
	logic        rst;
	logic [2:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic [3:0]  row;
	logic [4:0]  col;
	logic        pix;
	logic [4:0]  side;
	logic        vblk;
	logic        m1_c;
	logic        m2_c;
	logic        m1_a;
	logic        m2_a;
	logic [7:0]  glyph;
	logic        vr;
	logic        m1;
	logic        m2;
	logic        osc_run;
	logic        sck;
	logic        sda;
	logic        cs_n;
	int          bad_count;
	int          total_checks;

	always #12.5 clk = ~clk;

	// ==========================================
	// Design and host
	osdrc_top #(.FLASH_CYC(4)) i_dut (
		.I_CLK(clk), .I_RST(rst), .I_SCK(sck), .I_SDA(sda), .I_CS_N(cs_n),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
		.I_ROW(row), .I_COL(col), .I_PIX(pix), .I_RIM(side[4]), .I_MINBG(side[3]),
		.I_NB_RIM(side[2]), .I_NB_BG(side[1]), .I_NB_MARK(side[0]), .O_GLYPH(glyph),
		.O_VR(vr), .O_VG(), .O_VB(), .O_VBLK(vblk), .O_MONO1(m1), .O_MONO1_BLK(),
		.O_MONO2(m2), .O_MONO2_BLK(), .O_OSC_RUN(osc_run), .O_ROW_DBL(), .O_VPOS(), .O_HPOS()
	);
	// Sister builds share every input, so each routing option is judged on the same cells
	osdrc_top #(.OPTION(OPT_C)) i_dut_c (
		.I_CLK(clk), .I_RST(rst), .I_SCK(sck), .I_SDA(sda), .I_CS_N(cs_n),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(),
		.I_ROW(row), .I_COL(col), .I_PIX(pix), .I_RIM(side[4]), .I_MINBG(side[3]),
		.I_NB_RIM(side[2]), .I_NB_BG(side[1]), .I_NB_MARK(side[0]), .O_GLYPH(),
		.O_VR(), .O_VG(), .O_VB(), .O_VBLK(), .O_MONO1(m1_c), .O_MONO1_BLK(),
		.O_MONO2(m2_c), .O_MONO2_BLK(), .O_OSC_RUN(), .O_ROW_DBL(), .O_VPOS(), .O_HPOS()
	);
	osdrc_top #(.OPTION(OPT_A)) i_dut_a (
		.I_CLK(clk), .I_RST(rst), .I_SCK(sck), .I_SDA(sda), .I_CS_N(cs_n),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(),
		.I_ROW(row), .I_COL(col), .I_PIX(pix), .I_RIM(side[4]), .I_MINBG(side[3]),
		.I_NB_RIM(side[2]), .I_NB_BG(side[1]), .I_NB_MARK(side[0]), .O_GLYPH(),
		.O_VR(), .O_VG(), .O_VB(), .O_VBLK(), .O_MONO1(m1_a), .O_MONO1_BLK(),
		.O_MONO2(m2_a), .O_MONO2_BLK(), .O_OSC_RUN(), .O_ROW_DBL(), .O_VPOS(), .O_HPOS()
	);
	osdrc_host_model i_host (
		.i_clk(clk), .o_sck(sck), .o_sda(sda), .o_cs_n(cs_n)
	);

	// ==========================================
	// Checking and bus tasks
	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, input logic [15:0] exp);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_word("register", exp, rdata);
	endtask
	// Pixel is driven one cycle after the cell, video judged one cycle later
	// Expected bits: colour blank, red, option B mono1 mono2, option C pair, option A pair
	task automatic show(input logic [3:0] r, input logic [4:0] c, input logic [7:0] g, input logic p,
		input logic [7:0] exp);
		@(posedge clk);
		row <= r;
		col <= c;
		@(posedge clk);
		pix <= p;
		#1;
		chk_word("glyph", {8'h00, g}, {8'h00, glyph});
		@(posedge clk);
		pix <= 1'b0;
		#1;
		chk_word("blank colour mono outputs", {8'h00, exp}, {8'h00, vblk, vr, m1, m2, m1_c, m2_c, m1_a, m2_a});
	endtask
	task automatic wr_char(input logic [15:0] at, input logic [15:0] chr);
		i_host.frame_open();
		i_host.put_word(at);
		i_host.put_word(chr);
		i_host.frame_close();
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task automatic sc_regs();
		reg_rd(REG_CTRL, CTRL_RST);
		reg_rd(3'h5, 16'h0000);
		reg_wr(3'h6, 16'hFFFF);
		reg_rd(3'h6, 16'h0000);
		repeat (300) @(posedge clk);
		reg_rd(REG_STATUS, 16'h0050);
	endtask
	task automatic sc_one_byte();
		logic [7:0]  cmd [9];
		logic [15:0] exp [9];
		cmd = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h1C, 8'h21, 8'h39, 8'h38, 8'h20};
		exp = '{16'h0050, 16'h0054, 16'h0058, 16'h005C, 16'h0070, 16'h0071, 16'h0073, 16'h0071, 16'h0070};
		for (int k = 0; k < 9; k++)
		begin
			i_host.send1(cmd[k]);
			reg_rd(REG_STATUS, exp[k]);
		end
	endtask
	// Row 12 and the test mode word must leave every setting alone
	task automatic sc_pins();
		logic [15:0] w [6];
		w = '{16'h9C40, 16'h9C4B, 16'h9C85, 16'h9C4C, 16'h9843, 16'hB000};
		for (int k = 0; k < 6; k++)
			i_host.send2(w[k]);
		reg_rd(REG_ROUTE1, 16'h0801);
		reg_rd(REG_ROUTE2, 16'h0020);
		reg_rd(REG_SIZE, 16'h0008);
	endtask
	task automatic sc_chars();
		wr_char(16'h8800, 16'hD041);
		wr_char(16'h8801, 16'hD142);
		wr_char(16'h88A0, 16'hD143);
		i_host.frame_open();
		i_host.put_word(16'h8820);
		i_host.put_word(16'hD010);
		i_host.put_byte(8'h11);
		i_host.frame_close();
		show(4'h0, 5'h00, 8'h41, 1'b1, 8'hE8);
		show(4'h0, 5'h01, 8'h42, 1'b1, 8'h11);
		show(4'h1, 5'h01, 8'h11, 1'b1, 8'hEA);
		show(4'h5, 5'h00, 8'h43, 1'b1, 8'h04);
		show(4'h0, 5'h18, GLYPH_BLANK, 1'b0, 8'h00);
	endtask
	// Rim may spill into a marked cell on the colour channel, background may not
	task automatic sc_rim();
		i_host.send2(16'hB3C0);
		@(posedge clk);
		side <= 5'h06;
		show(4'h0, 5'h01, 8'h42, 1'b1, 8'h91);
		@(posedge clk);
		side <= 5'h02;
		show(4'h0, 5'h01, 8'h42, 1'b1, 8'h11);
		show(4'h0, 5'h00, 8'h41, 1'b0, 8'h80);
		@(posedge clk);
		side <= 5'h00;
		i_host.send2(16'hB200);
	endtask
	task automatic sc_clear();
		i_host.send1(8'h00);
		repeat (300) @(posedge clk);
		reg_rd(REG_ROUTE1, 16'h0000);
		reg_rd(REG_ROUTE2, 16'h0000);
		reg_rd(REG_SIZE, 16'h0000);
		reg_rd(REG_STATUS, 16'h0050);
		show(4'h0, 5'h00, GLYPH_BLANK, 1'b0, 8'h00);
	endtask
	task automatic sc_refuse();
		reg_wr(REG_CTRL, 16'h0000);
		i_host.send1(8'h1C);
		reg_rd(REG_STATUS, 16'h0050);
		reg_wr(REG_CTRL, 16'h0001);
		i_host.send1(8'h1C);
		reg_rd(REG_STATUS, 16'h0070);
	endtask

	// ==========================================
	// Main sequence and watchdog
	initial
	begin
		clk          = 1'b0;
		rst          = 1'b1;
		addr         = 3'h0;
		wdata        = 16'h0000;
		wr           = 1'b0;
		rd           = 1'b0;
		row          = 4'h0;
		col          = 5'h00;
		pix          = 1'b0;
		side         = 5'h00;
		bad_count    = 0;
		total_checks = 0;
		@(posedge clk);
		#1;
		chk_word("osc_run in reset", 16'h0001, {15'h0000, osc_run});
		chk_word("glyph in reset", {8'h00, GLYPH_BLANK}, {8'h00, glyph});
		@(posedge clk);
		rst <= 1'b0;
		sc_regs();
		sc_one_byte();
		sc_pins();
		sc_chars();
		sc_rim();
		sc_clear();
		sc_refuse();
		conclude();
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		bad_count++;
		conclude();
	end
endmodule
